// *** cro_map.svh ***
// Register offsets, field positions, reset values and opcodes of the return/clear unit
`ifndef CRO_MAP_SVH
`define CRO_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRO_OFF_CMD     8'h00
`define CRO_OFF_PC      8'h04
`define CRO_OFF_SP      8'h08
`define CRO_OFF_FLAGS   8'h0C
`define CRO_OFF_DP      8'h10
`define CRO_OFF_AB      8'h14
`define CRO_OFF_PORTD   8'h18
`define CRO_OFF_SAVE    8'h1C
`define CRO_OFF_STACK   8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CRO_FLAG_CY     0
`define CRO_FLAG_SKIP   1
`define CRO_FLAG_NOP    2
`define CRO_FLAG_LXY    3
`define CRO_CMD_BUSY    0
`define CRO_DP_Y_LSB    4
`define CRO_DP_Z_LSB    8
`define CRO_AB_B_LSB    4

// ----------------------------------------------------------------
// Opcodes (10-bit instruction words)
// ----------------------------------------------------------------
`define CRO_OP_CLR_CARRY 10'h006
`define CRO_OP_PORT_CLR  10'h014
`define CRO_OP_SUB_RET   10'h044
`define CRO_OP_INT_RET   10'h046

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define CRO_RST_ZERO    32'h0000_0000
`define CRO_PORT_BITS   8

`endif

// *** cro_pkg.sv ***
// Types shared by the return/clear unit
`default_nettype none
package cro_pkg;

	// Execution state, one-hot
	typedef enum logic [2:0] {
		CRO_IDLE = 3'b001,
		CRO_EXEC = 3'b010,
		CRO_RET2 = 3'b100
	} cro_state_e;

	// State saved on interrupt entry, a in the low bits
	typedef struct packed {
		logic       lxy;
		logic       nop;
		logic       skip;
		logic       cy;
		logic [1:0] z;
		logic [3:0] y;
		logic [3:0] x;
		logic [3:0] b;
		logic [3:0] a;
	} cro_save_s;

	// Live processor state touched by these operations
	typedef struct packed {
		logic       lxy;
		logic       nop;
		logic       skip;
		logic       cy;
		logic [1:0] z;
		logic [3:0] y;
		logic [3:0] x;
		logic [3:0] b;
		logic [3:0] a;
	} cro_cpu_s;

endpackage : cro_pkg
`default_nettype wire

// *** cro_stack.sv ***
// Return stack storage with one write port and two read ports
`default_nettype none
module cro_stack #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 14
) (
	input  wire logic                     clk_i,   // System clock
	input  wire logic                     ce_i,    // Clock enable
	input  wire logic                     we_i,    // Write strobe
	input  wire logic [$clog2(DEPTH)-1:0] widx_i,  // Write index
	input  wire logic [WIDTH-1:0]         wdat_i,  // Write data
	input  wire logic [$clog2(DEPTH)-1:0] ridx_a_i, // Read index, execution side
	output logic      [WIDTH-1:0]         rdat_a_o, // Read data, execution side
	input  wire logic [$clog2(DEPTH)-1:0] ridx_b_i, // Read index, bus side
	output logic      [WIDTH-1:0]         rdat_b_o  // Read data, bus side
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1 || WIDTH > 16) begin : g_chk
		$error("cro_stack: DEPTH must be a power of two >= 2, WIDTH 1..16");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];

	// Entries have no reset; software loads them before any return
	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem_q[widx_i] <= wdat_i;
		end
	end

	// Combinational reads so a return picks its target in one cycle
	always_comb begin
		rdat_a_o = mem_q[ridx_a_i];
		rdat_b_o = mem_q[ridx_b_i];
	end

endmodule : cro_stack
`default_nettype wire

// *** cro_top.sv ***
// Carry clear, port bit clear and return operations with a Wishbone register slave
`include "cro_map.svh"
`default_nettype none

//  Contract
// - Port-clear zeroes port bit chosen by Y (0..7); one word, one cycle.
// - Subroutine return loads PC from stack at SP, then SP minus one; two cycles.
// - Interrupt return loads PC from stack, decrements SP; one cycle, carry restored from saved state.
// - Interrupt return restores saved X, Y, Z, carry, skip and no-op mode status.
// - Interrupt return also restores load-suppression status, accumulator and B.
module cro_top #(
	parameter int PC_W     = 14,
	parameter int SK_DEPTH = 8
) (
	input  wire logic        clk_i,     // 200 MHz system clock
	input  wire logic        resetn_i,  // Asynchronous reset, active low
	input  wire logic        ce_i,      // Clock enable, freezes all state when low
	input  wire logic        wb_cyc_i,  // Wishbone cycle
	input  wire logic        wb_stb_i,  // Wishbone strobe
	input  wire logic        wb_we_i,   // Wishbone write enable
	input  wire logic [7:0]  wb_adr_i,  // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,  // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,  // Wishbone write data
	output logic      [31:0] wb_dat_o,  // Wishbone read data, registered
	output logic             wb_ack_o,  // Wishbone acknowledge, registered
	output logic      [7:0]  port_d_o,  // Output port bits, registered
	output logic             busy_o     // Operation in progress, registered
);

	localparam int SPW = $clog2(SK_DEPTH);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (PC_W < 1 || PC_W > 16 || SK_DEPTH < 2 || SK_DEPTH > 16) begin : g_chk
		$error("cro_top: PC_W must be 1..16 and SK_DEPTH 2..16");
	end

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// Two stages keep the release clean of the asynchronous edge
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cro_pkg::cro_state_e st_q, st_d;
	cro_pkg::cro_cpu_s   cpu_q, cpu_d;
	cro_pkg::cro_save_s  save_q, save_d;
	logic [PC_W-1:0]     pc_q, pc_d;
	logic [SPW-1:0]      sp_q, sp_d;
	logic [9:0]          op_q, op_d;
	logic [7:0]          portd_q, portd_d;
	logic                ack_q, ack_d;
	logic [31:0]         rdat_q, rdat_d;

	logic                acc, wr, rd_en;
	logic [31:0]         wmask, rmux;
	logic [PC_W-1:0]     sk_rdat, sk_bdat;
	logic                sk_we;
	logic [SPW-1:0]      sk_bidx;
	logic                stk_hit;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Ack comes one cycle after the strobe and drops the next cycle
	always_comb begin
		acc     = wb_cyc_i && wb_stb_i && !ack_q;
		wr      = acc && wb_we_i;
		rd_en   = acc && !wb_we_i;
		wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		stk_hit = wb_adr_i >= `CRO_OFF_STACK &&
		          wb_adr_i < (`CRO_OFF_STACK + 8'(SK_DEPTH * 4));
		sk_bidx = SPW'(wb_adr_i[7:2] - `CRO_OFF_STACK / 4);
		sk_we   = wr && stk_hit && st_q == cro_pkg::CRO_IDLE && wb_sel_i[0];
	end

	cro_stack #(
		.DEPTH (SK_DEPTH),
		.WIDTH (PC_W)
	) u_stack (
		.clk_i    (clk_i),
		.ce_i     (ce_i),
		.we_i     (sk_we),
		.widx_i   (sk_bidx),
		.wdat_i   (wb_dat_i[PC_W-1:0]),
		.ridx_a_i (sp_q),
		.rdat_a_o (sk_rdat),
		.ridx_b_i (sk_bidx),
		.rdat_b_o (sk_bdat)
	);

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rmux = `CRO_RST_ZERO;
		if (stk_hit) begin
			rmux = 32'(sk_bdat);
		end else begin
			unique case (wb_adr_i)
				`CRO_OFF_CMD:   rmux = {22'h00_0000, op_q[9:1], st_q != cro_pkg::CRO_IDLE};
				`CRO_OFF_PC:    rmux = 32'(pc_q);
				`CRO_OFF_SP:    rmux = 32'(sp_q);
				`CRO_OFF_FLAGS: rmux = {28'h000_0000, cpu_q.lxy, cpu_q.nop,
				                        cpu_q.skip, cpu_q.cy};
				`CRO_OFF_DP:    rmux = {22'h00_0000, cpu_q.z, cpu_q.y, cpu_q.x};
				`CRO_OFF_AB:    rmux = {24'h00_0000, cpu_q.b, cpu_q.a};
				`CRO_OFF_PORTD: rmux = {24'h00_0000, portd_q};
				`CRO_OFF_SAVE:  rmux = {10'h000, save_q};
				default:        rmux = `CRO_RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Next state: bus writes and instruction execution
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] nv;
		logic [31:0] cur;
		nv      = `CRO_RST_ZERO;
		cur     = `CRO_RST_ZERO;
		st_d    = st_q;
		cpu_d   = cpu_q;
		save_d  = save_q;
		pc_d    = pc_q;
		sp_d    = sp_q;
		op_d    = op_q;
		portd_d = portd_q;
		ack_d   = acc;
		rdat_d  = rd_en ? rmux : `CRO_RST_ZERO;

		// State writes are dropped while an operation runs
		if (wr && st_q == cro_pkg::CRO_IDLE && !stk_hit) begin
			cur = rmux;
			nv  = (wb_dat_i & wmask) | (cur & ~wmask);
			unique case (wb_adr_i)
				`CRO_OFF_CMD: begin
					op_d = nv[9:0];
					st_d = cro_pkg::CRO_EXEC;
				end
				`CRO_OFF_PC:    pc_d = nv[PC_W-1:0];
				`CRO_OFF_SP:    sp_d = nv[SPW-1:0];
				`CRO_OFF_FLAGS: begin
					cpu_d.cy   = nv[`CRO_FLAG_CY];
					cpu_d.skip = nv[`CRO_FLAG_SKIP];
					cpu_d.nop  = nv[`CRO_FLAG_NOP];
					cpu_d.lxy  = nv[`CRO_FLAG_LXY];
				end
				`CRO_OFF_DP: begin
					cpu_d.x = nv[3:0];
					cpu_d.y = nv[`CRO_DP_Y_LSB +: 4];
					cpu_d.z = nv[`CRO_DP_Z_LSB +: 2];
				end
				`CRO_OFF_AB: begin
					cpu_d.a = nv[3:0];
					cpu_d.b = nv[`CRO_AB_B_LSB +: 4];
				end
				`CRO_OFF_PORTD: portd_d = nv[7:0];
				`CRO_OFF_SAVE:  save_d  = cro_pkg::cro_save_s'(nv[21:0]);
				default: ;
			endcase
		end

		unique case (st_q)
			cro_pkg::CRO_IDLE: ;
			cro_pkg::CRO_EXEC: begin
				st_d = cro_pkg::CRO_IDLE;
				unique case (op_q)
					`CRO_OP_CLR_CARRY: begin
						cpu_d.cy   = 1'b0;
						cpu_d.skip = 1'b0;
					end
					`CRO_OP_PORT_CLR: begin
						if (cpu_q.y < 4'(`CRO_PORT_BITS)) begin
							portd_d[cpu_q.y[2:0]] = 1'b0;
						end
					end
					// load PC, SP drops next cycle
					`CRO_OP_SUB_RET: begin
						pc_d = sk_rdat;
						st_d = cro_pkg::CRO_RET2;
					end
					// load PC and pop in one cycle
					`CRO_OP_INT_RET: begin
						pc_d = sk_rdat;
						sp_d = sp_q - SPW'(1);
						cpu_d.x    = save_q.x;
						cpu_d.y    = save_q.y;
						cpu_d.z    = save_q.z;
						cpu_d.cy   = save_q.cy;
						cpu_d.skip = save_q.skip;
						cpu_d.nop  = save_q.nop;
						cpu_d.lxy  = save_q.lxy;
						cpu_d.a    = save_q.a;
						cpu_d.b    = save_q.b;
					end
					default: ;  // Other opcodes are not handled here
				endcase
			end
			cro_pkg::CRO_RET2: begin
				sp_d = sp_q - SPW'(1);
				st_d = cro_pkg::CRO_IDLE;
			end
			default: st_d = cro_pkg::CRO_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Clock enable freezes everything, bus handshake included
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= cro_pkg::CRO_IDLE;
			cpu_q   <= '0;
			save_q  <= '0;
			pc_q    <= '0;
			sp_q    <= '0;
			op_q    <= '0;
			portd_q <= '0;
			ack_q   <= 1'b0;
			rdat_q  <= `CRO_RST_ZERO;
		end else if (ce_i) begin
			st_q    <= st_d;
			cpu_q   <= cpu_d;
			save_q  <= save_d;
			pc_q    <= pc_d;
			sp_q    <= sp_d;
			op_q    <= op_d;
			portd_q <= portd_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
		end
	end

	// Busy mirrored in its own flop so the output stays registered
	logic busy_q;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else if (ce_i) begin
			busy_q <= st_d != cro_pkg::CRO_IDLE;
		end
	end

	// Outputs straight from flops
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign port_d_o = portd_q;
	assign busy_o   = busy_q;

endmodule : cro_top
`default_nettype wire

// *** cro_top_asserts.sv ***
// Port-level assertions for the return and clear unit
`include "cro_map.svh"
`default_nettype none
module cro_top_asserts (
	input wire logic        clk_i,    // Clock
	input wire logic        resetn_i, // Reset, active low
	input wire logic        ce_i,     // Clock enable
	input wire logic        wb_cyc_i, // Cycle
	input wire logic        wb_stb_i, // Strobe
	input wire logic        wb_we_i,  // Write
	input wire logic [7:0]  wb_adr_i, // Address
	input wire logic [3:0]  wb_sel_i, // Selects
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic        wb_ack_o, // Acknowledge
	input wire logic [7:0]  port_d_o, // Port bits
	input wire logic        busy_o    // Busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// A request the slave has not yet answered
	sequence s_take;
		wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
	endsequence
	a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("data not zero");
	// ----------------------------------------
	// Operations
	// ----------------------------------------
	a_busy_start: assert property ($rose(busy_o) |->
		wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h00))
		else $error("busy without command");
	a_busy_ends: assert property ($rose(busy_o) |-> ##[1:3] !busy_o)
		else $error("busy too long");
	// Port clear may only drop bits, never raise them
	a_port_clear: assert property (busy_o |=> (port_d_o & ~$past(port_d_o)) == 8'h00)
		else $error("port bit raised");
	a_port_cause: assert property ($changed(port_d_o) |-> $past(busy_o) || wb_ack_o)
		else $error("port changed alone");
	// A command write taken while idle, opcode lanes selected
	sequence s_cmd_take;
		s_take ##0 (wb_we_i && wb_adr_i == `CRO_OFF_CMD && wb_sel_i[1:0] == 2'b11 && !busy_o);
	endsequence
	// Only a subroutine return spends a second cycle, on the pointer
	a_ret_two_cycles: assert property (
		s_cmd_take ##0 (wb_dat_i[9:0] == `CRO_OP_SUB_RET) ##1 ce_i ##1 ce_i |->
		($past(busy_o) && busy_o) ##1 !busy_o)
		else $error("subroutine return length wrong");
	a_op_one_cycle: assert property (
		s_cmd_take ##0 (wb_dat_i[9:0] != `CRO_OP_SUB_RET) ##1 ce_i |->
		busy_o ##1 !busy_o)
		else $error("single cycle op length wrong");
endmodule : cro_top_asserts
bind cro_top cro_top_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.port_d_o(port_d_o), .busy_o(busy_o));
`default_nettype wire

// *** test_cpu_return_and_clear_ops.sv ***
// Self-checking bench for the return and clear unit
`include "cro_map.svh"
`default_nettype none
module test_cpu_return_and_clear_ops;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, resetn_i, ce_i, cyc, stb, we, ack, busy;
	logic [7:0] adr, port;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	int mismatches, n_checks;
	cro_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .port_d_o(port), .busy_o(busy));
	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done;
		$display("mismatches %0d checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Single classic cycle, held until ack is seen
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			mismatches++;
			test_done();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask : rd
	// Issue an opcode and wait for the unit to go idle
	task automatic op(input logic [9:0] c);
		int n;
		n = 0;
		bus(1'b1, `CRO_OFF_CMD, {22'h0, c});
		while (busy !== 1'b0 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (busy !== 1'b0) begin
			mismatches++;
			test_done();
		end
	endtask : op
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_carry;
		bus(1'b1, `CRO_OFF_FLAGS, 32'h0000_000F);
		op(`CRO_OP_CLR_CARRY);
		rd(`CRO_OFF_FLAGS, 32'h0000_000C);
	endtask : t_carry
	// Walk Y over every bit and one index past the port
	task automatic t_port;
		logic [7:0] e;
		e = 8'hFF;
		bus(1'b1, `CRO_OFF_PORTD, 32'h0000_00FF);
		for (int y = 0; y < 9; y++) begin
			bus(1'b1, `CRO_OFF_DP, 32'(y) << 4);
			op(`CRO_OP_PORT_CLR);
			if (y < 8) e[y] = 1'b0;
			chk({24'h0, port}, {24'h0, e});
		end
	endtask : t_port
	task automatic t_sub(input logic [2:0] sp, input logic [13:0] pc);
		bus(1'b1, `CRO_OFF_STACK + 8'(sp) * 8'd4, {18'h0, pc});
		bus(1'b1, `CRO_OFF_SP, {29'h0, sp});
		op(`CRO_OP_SUB_RET);
		rd(`CRO_OFF_PC, {18'h0, pc});
		rd(`CRO_OFF_SP, {29'h0, sp - 3'd1});
	endtask : t_sub
	// Saved state differs from live state in every field
	task automatic t_int;
		bus(1'b1, `CRO_OFF_STACK + 8'd20, 32'h0000_02AB);
		bus(1'b1, `CRO_OFF_SP, 32'h0000_0005);
		bus(1'b1, `CRO_OFF_FLAGS, 32'h0000_0002);
		bus(1'b1, `CRO_OFF_DP, 32'h0000_0000);
		bus(1'b1, `CRO_OFF_AB, 32'h0000_0000);
		bus(1'b1, `CRO_OFF_SAVE, 32'h0036_C3A5);
		op(`CRO_OP_INT_RET);
		rd(`CRO_OFF_PC, 32'h0000_02AB);
		rd(`CRO_OFF_SP, 32'h0000_0004);
		rd(`CRO_OFF_FLAGS, 32'h0000_000D);
		rd(`CRO_OFF_DP, 32'h0000_02C3);
		rd(`CRO_OFF_AB, 32'h0000_00A5);
		rd(`CRO_OFF_SAVE, 32'h0036_C3A5);
		rd(`CRO_OFF_CMD, 32'h0000_0046);
	endtask : t_int
	// Clock enable low holds a port write off until it rises again
	task automatic t_freeze;
		ce_i <= 1'b0;
		fork
			bus(1'b1, `CRO_OFF_PORTD, 32'h0000_005A);
			begin
				repeat (4) @(posedge clk_i);
				chk({31'h0, ack}, 32'h0000_0000);
				chk({24'h0, port}, 32'h0000_0000);
				ce_i <= 1'b1;
			end
		join
		chk({24'h0, port}, 32'h0000_005A);
	endtask : t_freeze
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mismatches = 0;
		n_checks = 0;
		resetn_i = 1'b0;
		ce_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0000_0000;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(8'h30, 32'h0000_0000);
		t_carry();
		t_port();
		t_freeze();
		t_sub(3'd3, 14'h1234);
		t_sub(3'd0, 14'h0ABC);
		t_int();
		test_done();
	end
endmodule : test_cpu_return_and_clear_ops
`default_nettype wire
